// *** rtl/pia_arbiter.sv ***
// interrupt recognition, acknowledge and rank arbitration
`timescale 1ns/1ns
`include "pia_defs.svh"
module pia_arbiter (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // cpu side
  input wire logic at_boundary,
  output logic [2:0] priority_mask_field,
  output logic vec_valid,
  output logic [7:0] vec_num,
  output logic [8:0] vec_addr,
  output logic spurious,
  // request sources
  input wire logic [7:1] irq_n,
  input wire logic tick_req,
  input wire logic [pia_pkg::PIA_NMOD*3-1:0] mod_level,
  input wire logic [pia_pkg::PIA_NMOD*4-1:0] mod_rank,
  input wire logic [pia_pkg::PIA_NMOD*8-1:0] mod_vector,
  output logic [pia_pkg::PIA_NMOD-1:0] mod_ack,
  output logic int_term,
  // external bus
  output logic [23:0] addr_out,
  output logic [2:0] function_code,
  output logic ext_iack,
  output logic cs_match_en,
  input wire logic [7:0] data_in,
  input wire logic [1:0] data_size_acknowledge_n,
  input wire logic autovector_request_n,
  input wire logic bus_error_input_n,
  output logic bus_error_out
);
  import pia_pkg::*;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [2:0] top_level(input logic [7:1] r);
    logic [2:0] lv;
    lv = 3'h0;
    for (int k = 1; k <= 7; k++) begin
      if (r[k]) begin
        lv = k[2:0];
      end
    end
    return lv;
  endfunction

  pia_state_type state;
  logic [2:0] mask, cur_lvl, next_lvl, tick_lvl;
  logic [3:0] siu_rank, siu_eff, best_rank, win_rank;
  logic [7:0] tmo, last_vec, best_vec;
  logic [7:1] samp_low, req_valid, req_all, eligible;
  logic [15:0] tick_ctrl;
  logic bmon_en, valid7_d, nmi_pend, last_spur, mask_wr, tick_on, start, tick_at, ext_at, siu_wins;
  logic [PIA_NMOD-1:0] best_hot;
  logic [PIA_NMOD*4-1:0] mod_cont;
  logic [PIA_NMOD*7-1:0] mod_req;

  assign mask_wr = reg_wr && (reg_addr == `PIA_OFF_MASK);
  assign priority_mask_field = mask;

  // ----------------------------------------
  // request sampling
  // ----------------------------------------
  // two-sample qualification
  always_ff @(posedge mclk) begin
    if (reset) begin
      samp_low <= 7'h00;
      req_valid <= 7'h00;
    end else begin
      samp_low <= ~irq_n;
      req_valid <= ~irq_n & samp_low;
    end
  end

  // level seven edge and mask write
  always_ff @(posedge mclk) begin
    if (reset) begin
      valid7_d <= 1'b0;
      nmi_pend <= 1'b0;
    end else begin
      valid7_d <= req_valid[7];
      if ((req_valid[7] && !valid7_d) || (mask_wr && req_valid[7])) begin
        nmi_pend <= 1'b1;
      end else if (start && next_lvl == `PIA_NMI_LVL) begin
        nmi_pend <= 1'b0;
      end
    end
  end

  assign tick_lvl = tick_ctrl[`PIA_TICK_MSB:`PIA_TICK_LSB];
  assign tick_on = tick_req && (tick_lvl != 3'h0);

  // ----------------------------------------
  // per-level request and mask
  // ----------------------------------------
  genvar gi;
  genvar gk;
  generate
    for (gi = 0; gi < PIA_NMOD; gi++) begin : g_mod
      for (gk = 1; gk <= 7; gk++) begin : g_lv
        assign mod_req[gi*7+gk-1] = (mod_level[gi*3 +: 3] == 3'(gk));
      end
      // only sources at the acknowledged level contend
      assign mod_cont[gi*4 +: 4] =
        (state == PIA_ARB && mod_level[gi*3 +: 3] == cur_lvl) ? mod_rank[gi*4 +: 4] : 4'h0;
    end
    for (gk = 1; gk <= 7; gk++) begin : g_level
      logic any_mod;
      always_comb begin
        any_mod = 1'b0;
        for (int m = 0; m < PIA_NMOD; m++) begin
          any_mod = any_mod | mod_req[m*7+gk-1];
        end
      end
      if (gk == 7) begin : g_top
        assign req_all[gk] = nmi_pend | any_mod | (tick_on && tick_lvl == 3'(gk));
        assign eligible[gk] = req_all[gk];
      end else begin : g_low
        assign req_all[gk] = req_valid[gk] | any_mod | (tick_on && tick_lvl == 3'(gk));
        assign eligible[gk] = req_all[gk] && (3'(gk) > mask);
      end
    end
  endgenerate

  assign next_lvl = top_level(eligible);
  assign start = (state == PIA_IDLE) && at_boundary && (next_lvl != 3'h0);

  // ----------------------------------------
  // rank contention
  // ----------------------------------------
  assign tick_at = tick_on && (tick_lvl == cur_lvl);
  assign ext_at = (cur_lvl == `PIA_NMI_LVL) ? req_valid[7] : req_valid[cur_lvl];
  // integration unit stands for all external sources
  assign siu_eff = (state == PIA_ARB && (tick_at || ext_at)) ? siu_rank : `PIA_RANK_NONE;

  always_comb begin
    best_rank = 4'h0;
    best_hot = '0;
    best_vec = 8'h00;
    for (int m = 0; m < PIA_NMOD; m++) begin
      if (mod_cont[m*4 +: 4] > best_rank) begin
        best_rank = mod_cont[m*4 +: 4];
        best_hot = '0;
        best_hot[m] = 1'b1;
        best_vec = mod_vector[m*8 +: 8];
      end
    end
  end

  assign siu_wins = (siu_eff != 4'h0) && (siu_eff >= best_rank);
  assign win_rank = siu_wins ? siu_eff : best_rank;

  // ----------------------------------------
  // acknowledge sequence
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= PIA_IDLE;
      cur_lvl <= 3'h0;
      tmo <= 8'h00;
      vec_num <= 8'h00;
      spurious <= 1'b0;
      int_term <= 1'b0;
      bus_error_out <= 1'b0;
      mod_ack <= '0;
    end else begin
      bus_error_out <= 1'b0;
      mod_ack <= '0;
      case (state)
        PIA_IDLE: begin
          int_term <= 1'b0;
          if (start) begin
            cur_lvl <= next_lvl;
            state <= PIA_ARB;
          end
        end
        PIA_ARB: begin
          tmo <= 8'h00;
          // no contender ends early with bus error
          if (win_rank == 4'h0) begin
            vec_num <= `PIA_SPUR_VEC;
            spurious <= 1'b1;
            bus_error_out <= 1'b1;
            int_term <= 1'b0;
            state <= PIA_DONE;
          end else if (!siu_wins) begin
            vec_num <= best_vec;
            spurious <= 1'b0;
            int_term <= 1'b1;
            mod_ack <= best_hot;
            state <= PIA_DONE;
          end else if (tick_at) begin
            vec_num <= tick_ctrl[7:0];
            spurious <= 1'b0;
            int_term <= 1'b1;
            state <= PIA_DONE;
          end else begin
            state <= PIA_EXT;
          end
        end
        PIA_EXT: begin
          if (data_size_acknowledge_n != 2'h3) begin
            vec_num <= data_in;
            spurious <= 1'b0;
            state <= PIA_DONE;
          end else if (!autovector_request_n) begin
            vec_num <= `PIA_AUTO_BASE + {5'h00, cur_lvl};
            spurious <= 1'b0;
            state <= PIA_DONE;
          end else if (!bus_error_input_n) begin
            vec_num <= `PIA_SPUR_VEC;
            spurious <= 1'b1;
            state <= PIA_DONE;
          end else if (bmon_en && tmo == `PIA_BMON_CYC) begin
            vec_num <= `PIA_SPUR_VEC;
            spurious <= 1'b1;
            bus_error_out <= 1'b1;
            state <= PIA_DONE;
          end else begin
            tmo <= tmo + 8'h01;
          end
        end
        PIA_DONE: begin
          state <= PIA_IDLE;
        end
        default: begin
          state <= PIA_IDLE;
        end
      endcase
    end
  end

  assign vec_valid = (state == PIA_DONE);
  // vector table in lowest 512 bytes
  assign vec_addr = {vec_num, 1'b0};
  // external bus only if integration unit wins
  assign ext_iack = (state == PIA_EXT);
  // chip-select match on external cycles only
  assign cs_match_en = ext_iack;

  always_ff @(posedge mclk) begin
    if (reset) begin
      addr_out <= 24'h000000;
      function_code <= 3'h0;
    end else if (start) begin
      addr_out <= {`PIA_ADDR_HI, next_lvl, 1'b1};
      function_code <= `PIA_FC_CPU;
    end else if (state == PIA_DONE) begin
      addr_out <= 24'h000000;
      function_code <= 3'h0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // mask reset to seven
  always_ff @(posedge mclk) begin
    if (reset) begin
      mask <= `PIA_MASK_RST;
    end else if (start) begin
      mask <= next_lvl;
    end else if (mask_wr) begin
      mask <= reg_wdata[`PIA_MASK_MSB:`PIA_MASK_LSB];
    end
  end

  // integration unit rank resets to fifteen
  always_ff @(posedge mclk) begin
    if (reset) begin
      siu_rank <= `PIA_RANK_RST;
      bmon_en <= `PIA_BMON_RST;
      tick_ctrl <= `PIA_TICK_RST;
    end else if (reg_wr) begin
      if (reg_addr == `PIA_OFF_RANK) begin
        siu_rank <= reg_wdata[3:0];
        bmon_en <= reg_wdata[`PIA_BMON_BIT];
      end
      if (reg_addr == `PIA_OFF_TICK) begin
        tick_ctrl <= {5'h00, reg_wdata[10:0]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      last_vec <= 8'h00;
      last_spur <= 1'b0;
    end else if (state == PIA_DONE) begin
      last_vec <= vec_num;
      last_spur <= spurious;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PIA_OFF_MASK: reg_rdata <= {8'h00, mask, 5'h00};
        `PIA_OFF_RANK: reg_rdata <= {8'h00, bmon_en, 3'h0, siu_rank};
        `PIA_OFF_TICK: reg_rdata <= tick_ctrl;
        `PIA_OFF_STAT: reg_rdata <= {3'h0, last_spur, last_vec, nmi_pend, cur_lvl};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_mask_reset;
    @(posedge mclk) reset |=> (mask == 3'h7);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not seven after reset");

  property p_mask_block;
    @(posedge mclk) disable iff (reset)
      start && next_lvl != 3'h7 |-> next_lvl > mask;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked level was taken");

  property p_two_samples;
    @(posedge mclk) disable iff (reset)
      req_valid[1] |-> $past(!irq_n[1], 1) && $past(!irq_n[1], 2);
  endproperty
  a_two_samples: assert property (p_two_samples) else $error("request valid too early");

  property p_nmi_edge;
    @(posedge mclk) disable iff (reset)
      $rose(req_valid[7]) |=> nmi_pend;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("level seven edge lost");

  sequence s_begin;
    start ##1 (state == PIA_ARB);
  endsequence
  property p_iack_level;
    @(posedge mclk) disable iff (reset)
      s_begin |-> (mask == cur_lvl) && (addr_out[3:1] == cur_lvl);
  endproperty
  a_iack_level: assert property (p_iack_level) else $error("level not on bus or mask");

  property p_cpu_space;
    @(posedge mclk) disable iff (reset)
      (state == PIA_EXT) |-> function_code == 3'h7 && addr_out[23:4] == 20'hfffff && addr_out[0];
  endproperty
  a_cpu_space: assert property (p_cpu_space) else $error("bad acknowledge address");

  property p_no_contend;
    @(posedge mclk) disable iff (reset)
      (state == PIA_ARB) && win_rank == 4'h0 |=> vec_valid && spurious && bus_error_out;
  endproperty
  a_no_contend: assert property (p_no_contend) else $error("no contender not spurious");

  property p_tick_first;
    @(posedge mclk) disable iff (reset)
      (state == PIA_ARB) && siu_wins && tick_at |=> !ext_iack && int_term;
  endproperty
  a_tick_first: assert property (p_tick_first) else $error("tick timer not favoured");

  property p_bmon;
    @(posedge mclk) disable iff (reset)
      (state == PIA_EXT) && bmon_en && tmo == 8'h40 && data_size_acknowledge_n == 2'h3
      && autovector_request_n && bus_error_input_n |=> bus_error_out && spurious ##1 !vec_valid;
  endproperty
  a_bmon: assert property (p_bmon) else $error("bus monitor timeout missed");

  property p_autovec;
    @(posedge mclk) disable iff (reset)
      (state == PIA_EXT) && data_size_acknowledge_n == 2'h3 && !autovector_request_n
      |=> vec_num == 8'h18 + {5'h00, cur_lvl};
  endproperty
  a_autovec: assert property (p_autovec) else $error("autovector number wrong");
endmodule

// *** rtl/pia_defs.svh ***
// constants for the prioritized interrupt arbiter
`ifndef PIA_DEFS_SVH
`define PIA_DEFS_SVH
`define PIA_OFF_MASK 3'h0
`define PIA_OFF_RANK 3'h1
`define PIA_OFF_TICK 3'h2
`define PIA_OFF_STAT 3'h3
`define PIA_MASK_MSB 7
`define PIA_MASK_LSB 5
`define PIA_MASK_RST 3'h7
`define PIA_RANK_RST 4'hf
`define PIA_RANK_NONE 4'h0
`define PIA_BMON_BIT 7
`define PIA_BMON_RST 1'h1
`define PIA_TICK_MSB 10
`define PIA_TICK_LSB 8
`define PIA_TICK_RST 16'h0000
`define PIA_BMON_CYC 8'h40
`define PIA_SPUR_VEC 8'h18
`define PIA_AUTO_BASE 8'h18
`define PIA_FC_CPU 3'h7
`define PIA_ADDR_HI 20'hfffff
`define PIA_NMI_LVL 3'h7
`endif

// *** rtl/pia_pkg.sv ***
// types for the prioritized interrupt arbiter
package pia_pkg;
  localparam int PIA_NMOD = 2;
  typedef enum logic [1:0] {
    PIA_IDLE,
    PIA_ARB,
    PIA_EXT,
    PIA_DONE
  } pia_state_type;
endpackage

// *** verif/pia_partner.sv ***
// model of an external requesting device
`timescale 1ns/1ns
module pia_partner (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // commands from bench
  input wire logic go,
  input wire logic [2:0] lvl,
  input wire logic [1:0] mode,
  input wire logic [7:0] vec,
  // acknowledge seen on bus
  input wire logic ext_iack,
  input wire logic [23:0] addr_out,
  // driven lines
  output logic [7:1] irq_n,
  output logic [7:0] data_in,
  output logic [1:0] size_ack_n,
  output logic autov_n,
  output logic buserr_n
);
  logic active;
  logic [2:0] cur;
  // one line per level, held low
  assign irq_n = active ? ~(7'h01 << (cur - 3'h1)) : 7'h7f;
  always @(posedge mclk) begin
    size_ack_n <= 2'h3;
    autov_n <= 1'b1;
    buserr_n <= 1'b1;
    data_in <= ~data_in;
    if (reset) begin
      active <= 1'b0;
      cur <= 3'h0;
      data_in <= 8'h00;
    end else if (go) begin
      active <= 1'b1;
      cur <= lvl;
    end else if (active && ext_iack && addr_out[3:1] == cur) begin
      active <= 1'b0;
      if (mode == 2'h0) begin
        data_in <= vec;
        size_ack_n <= 2'h2;
      end
      if (mode == 2'h1) begin
        autov_n <= 1'b0;
      end
      if (mode == 2'h3) begin
        buserr_n <= 1'b0;
      end
    end
  end
endmodule

// *** verif/pia_arbiter_tb.sv ***
// self-checking bench for the interrupt arbiter
`timescale 1ns/1ns
`include "pia_defs.svh"
module pia_arbiter_tb;
  import pia_pkg::*;
  logic mclk, reset, reg_wr, reg_rd, at_boundary, tick_req, go;
  logic vec_valid, spurious, int_term, ext_iack, cs_match_en, bus_error_out;
  logic autov_n, buserr_n, be_seen, cs_bad, hit;
  logic [2:0] reg_addr, lvl, priority_mask_field, function_code, seen_fc;
  logic [1:0] mode, mod_ack, size_ack_n;
  logic [15:0] reg_wdata, reg_rdata, mod_vector;
  logic [7:0] pvec, vec_num, data_in, v1, v2;
  logic [8:0] vec_addr;
  logic [5:0] mod_level;
  logic [7:0] mod_rank;
  logic [23:0] addr_out, seen_addr;
  logic [7:1] irq_n;
  logic [31:0] seed;
  int mismatches, checks_done;
  pia_arbiter i_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .at_boundary(at_boundary),
    .priority_mask_field(priority_mask_field), .vec_valid(vec_valid), .vec_num(vec_num),
    .vec_addr(vec_addr), .spurious(spurious), .irq_n(irq_n), .tick_req(tick_req),
    .mod_level(mod_level), .mod_rank(mod_rank), .mod_vector(mod_vector), .mod_ack(mod_ack),
    .int_term(int_term), .addr_out(addr_out), .function_code(function_code), .ext_iack(ext_iack),
    .cs_match_en(cs_match_en), .data_in(data_in), .data_size_acknowledge_n(size_ack_n),
    .autovector_request_n(autov_n), .bus_error_input_n(buserr_n), .bus_error_out(bus_error_out));
  pia_partner i_far (.mclk(mclk), .reset(reset), .go(go), .lvl(lvl), .mode(mode), .vec(pvec),
    .ext_iack(ext_iack), .addr_out(addr_out), .irq_n(irq_n), .data_in(data_in), .size_ack_n(size_ack_n),
    .autov_n(autov_n), .buserr_n(buserr_n));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // monitors of the acknowledge cycle
  always @(negedge mclk) begin
    if (bus_error_out === 1'b1) be_seen = 1'b1;
    if (vec_valid === 1'b1) hit = 1'b1;
    if (cs_match_en !== ext_iack) cs_bad = 1'b1;
    if (ext_iack === 1'b1) begin
      seen_addr = addr_out;
      seen_fc = function_code;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input logic [2:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    cmp_word(24'(reg_rdata), 24'(exp));
  endtask
  task automatic quiet(input int n);
    hit = 1'b0;
    repeat (n) @(negedge mclk);
    cmp_flag(hit, 1'b0);
  endtask
  task automatic expect_vec(input logic [7:0] v, input logic sp, it, be, input logic [1:0] ma);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (vec_valid !== 1'b1 && n < 200);
    cmp_flag(vec_valid, 1'b1);
    cmp_word(24'(vec_num), 24'(v));
    cmp_word(24'(vec_addr), 24'({v, 1'b0}));
    cmp_flag(spurious, sp);
    cmp_flag(int_term, it);
    cmp_word(24'(mod_ack), 24'(ma));
    @(negedge mclk);
    cmp_flag(be_seen, be);
    be_seen = 1'b0;
  endtask
  task automatic ext_req(input logic [2:0] l, input logic [1:0] m, input logic [7:0] v);
    @(posedge mclk);
    go <= 1'b1;
    lvl <= l;
    mode <= m;
    pvec <= v;
    @(posedge mclk);
    go <= 1'b0;
  endtask
  task automatic ext_chk(input logic [2:0] l, input logic [1:0] m, input logic [7:0] v);
    logic [7:0] e;
    e = (m == 2'h0) ? v : (m == 2'h1) ? `PIA_AUTO_BASE + 8'(l) : `PIA_SPUR_VEC;
    expect_vec(e, m[1], 1'b0, m == 2'h2, 2'h0);
    cmp_word(seen_addr, {`PIA_ADDR_HI, l, 1'b1});
    cmp_word(24'(seen_fc), 24'(`PIA_FC_CPU));
    cmp_word(24'(priority_mask_field), 24'(l));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    {reset, reg_wr, reg_rd, at_boundary, tick_req, go, be_seen, cs_bad, hit} = 9'h100;
    {reg_addr, reg_wdata, lvl, mode, pvec, mod_level, mod_rank, mod_vector} = '0;
    seed = 32'd44838;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    reg_check(3'h0, 16'h00e0);
    reg_check(3'h1, 16'h008f);
    reg_check(3'h5, 16'h0000);
    seed = xs(seed);
    v1 = seed[7:0];
    ext_req(3'h3, 2'h0, v1);
    quiet(20);
    reg_write(3'h0, 16'h0000);
    quiet(10);
    at_boundary <= 1'b1;
    ext_chk(3'h3, 2'h0, v1);
    reg_write(3'h0, 16'h00e0);
    run_ext_seven: ext_req(3'h7, 2'h1, v1);
    ext_chk(3'h7, 2'h1, v1);
    reg_write(3'h0, 16'h0000);
    at_boundary <= 1'b0;
    ext_req(3'h2, 2'h0, v1);
    mod_level <= 6'h06;
    mod_rank <= 8'h05;
    mod_vector <= {8'h00, v1 ^ 8'h5a};
    repeat (4) @(posedge mclk);
    at_boundary <= 1'b1;
    expect_vec(v1 ^ 8'h5a, 1'b0, 1'b1, 1'b0, 2'h1);
    mod_level <= 6'h00;
    reg_write(3'h0, 16'h0000);
    ext_chk(3'h2, 2'h0, v1);
    reg_write(3'h0, 16'h0000);
    mod_level <= 6'h24;
    mod_rank <= 8'h93;
    mod_vector <= {v1, ~v1};
    expect_vec(v1, 1'b0, 1'b1, 1'b0, 2'h2);
    mod_level <= 6'h00;
    reg_write(3'h0, 16'h0000);
    mod_level <= 6'h04;
    mod_rank <= 8'h00;
    expect_vec(`PIA_SPUR_VEC, 1'b1, 1'b0, 1'b1, 2'h0);
    mod_level <= 6'h00;
    reg_write(3'h2, {5'h00, 3'h5, v1});
    reg_write(3'h0, 16'h0000);
    ext_req(3'h5, 2'h0, ~v1);
    tick_req <= 1'b1;
    expect_vec(v1, 1'b0, 1'b1, 1'b0, 2'h0);
    tick_req <= 1'b0;
    reg_write(3'h0, 16'h0000);
    ext_chk(3'h5, 2'h0, ~v1);
    reg_write(3'h2, 16'h0000);
    reg_write(3'h0, 16'h0000);
    tick_req <= 1'b1;
    quiet(20);
    tick_req <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      reg_write(3'h0, 16'h0000);
      ext_req(3'(seed[15:8] % 6) + 3'h1, 2'(i), seed[7:0]);
      ext_chk(3'(seed[15:8] % 6) + 3'h1, 2'(i), seed[7:0]);
    end
    cmp_flag(cs_bad, 1'b0);
    tally_and_finish;
  end
endmodule
